/* File: inc/cmhl_pkg.sv */
// Package: register map, field layout and event carrier for the history lists
package cmhl_pkg;

	// Printed register offsets are indices; byte address is four times this
	localparam logic [15:0] LAST_TX_IDX = 16'hFF42;
	localparam logic [15:0] RX_PORT_IDX = 16'hFF44;
	localparam logic [15:0] LAST_RX_IDX = 16'hFF9F;
	localparam logic [15:0] CTRL_IDX = 16'hFFA0;
	localparam logic [15:0] IRQ_STAT_IDX = 16'hFFA1;
	localparam logic [15:0] IRQ_MASK_IDX = 16'hFFA2;
	localparam logic [15:0] TX_PORT_IDX = 16'hFFA3;
	localparam int ADDR_W = 18;

	// History port layout
	localparam int PORT_OVF_BIT = 0;
	localparam int PORT_EMPTY_BIT = 1;
	localparam int PORT_DATA_LSB = 8;

	// Control register: bit 0 holds the block in initialization mode
	localparam int CTRL_INIT_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;

	// Interrupt status and mask layout
	localparam int IRQ_W = 4;
	localparam int IRQ_RX_STORED = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_RX_OVF = 2;
	localparam int IRQ_TX_OVF = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

	// Entries kept in sequence before overflow
	localparam int RX_KEEP = 22;
	localparam int TX_KEEP = 6;
	localparam int BUF_NUM_W = 4;

	// One stored or transmitted frame, with its message buffer number
	typedef struct packed {
		logic valid;
		logic [BUF_NUM_W-1:0] buf_num;
	} cmhl_evt_type;

endpackage

/* File: design/cmhl_list.sv */
// One history list: circular store of buffer numbers with overflow
`timescale 1ns/1ps
`default_nettype none
module cmhl_list #(
	parameter int KEEP = 22,
	parameter int PW = $clog2(KEEP)
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_init,
	input wire logic i_take,
	input wire logic i_clr_ovf,
	input wire cmhl_pkg::cmhl_evt_type i_evt,
	// State
	output logic o_empty,
	output logic o_ovf,
	output logic [7:0] o_last,
	output logic [7:0] o_head,
	output logic [PW:0] o_count
);

	logic [cmhl_pkg::BUF_NUM_W-1:0] mem_q [KEEP];
	logic [cmhl_pkg::BUF_NUM_W-1:0] mem_d [KEEP];
	logic [PW-1:0] in_q, in_d, get_q, get_d, wr_idx;
	logic [PW:0] count_q, count_d;
	logic ovf_q, ovf_d, wr, take, full, seq;

	function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
		return (p == PW'(KEEP - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [PW-1:0] dec(input logic [PW-1:0] p);
		return (p == '0) ? PW'(KEEP - 1) : p - 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pointer, count and overflow next state
	always_comb begin
		wr = i_evt.valid && !i_init;
		take = i_take && (count_q != '0);
		full = (count_q == (PW+1)'(KEEP));
		// Once full or overflowed, new numbers replace the newest entry
		seq = wr && !ovf_q && !full;
		wr_idx = seq ? in_q : dec(in_q);
		in_d = seq ? inc(in_q) : in_q;
		get_d = take ? inc(get_q) : get_q;
		count_d = count_q - (PW+1)'(take) + (PW+1)'(seq);
		ovf_d = ovf_q;
		if (i_clr_ovf)
			ovf_d = 1'b0;
		// Set wins over a clear in the same cycle
		if (wr && (ovf_q || full))
			ovf_d = 1'b1;
		if (i_init) begin
			in_d = '0;
			get_d = '0;
			count_d = '0;
			ovf_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_q <= '0;
			get_q <= '0;
			count_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			in_q <= in_d;
			get_q <= get_d;
			count_q <= count_d;
			ovf_q <= ovf_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Entry storage; contents are undefined until first written
	for (genvar i = 0; i < KEEP; i++) begin : g_ent
		always_comb begin
			mem_d[i] = (wr && wr_idx == PW'(i)) ? i_evt.buf_num : mem_q[i];
		end
		always_ff @(posedge i_clk) begin
			mem_q[i] <= mem_d[i];
		end
	end

	// Outputs seen by the register file
	assign o_empty = (count_q == '0);
	assign o_ovf = ovf_q;
	assign o_count = count_q;
	assign o_last = 8'(mem_q[dec(in_q)]);
	assign o_head = 8'(mem_q[get_q]);

endmodule // cmhl_list
`default_nettype wire

/* File: design/cmhl_top.sv */
// Receive and transmit message history lists behind an APB register file
//
// Functional notes
// - Last-received register returns the newest stored buffer number, 0 to 15.
// - Last-received value undefined before any store and after init exit.
// - Receive port bits 15:8 return the list entry at the get index.
// - Receive port bit 1 reads 0 with unread entries, else 1.
// - Overflow after 23 stores; 22 kept, later ones overwrite the newest.
// - Without overflow, unread entries stay and each new store is appended.
// - During overflow a store never clears the empty flag; reads still set it.
// - Writing 1 to receive port bit 0 clears overflow; 0 and others ignored.
// - Last-transmitted register returns the newest transmitted buffer number.
// - Last-transmitted value undefined before any transmit and after init exit.
// - Transmit empty flag is 0 with unread entries, 1 when all are read.
`timescale 1ns/1ps
`default_nettype none
module cmhl_top #(
	parameter int RX_KEEP = cmhl_pkg::RX_KEEP,
	parameter int TX_KEEP = cmhl_pkg::TX_KEEP
) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [cmhl_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Frame events from the message buffers
	input wire cmhl_pkg::cmhl_evt_type I_RX_EVT,
	input wire cmhl_pkg::cmhl_evt_type I_TX_EVT,
	// Interrupt
	output logic O_IRQ
);

	localparam int RPW = $clog2(RX_KEEP);
	localparam int TPW = $clog2(TX_KEEP);

	logic [15:0] idx;
	logic setup, acc, rd_acc, wr_acc, mapped;
	logic sel_ltx, sel_rxp, sel_lrx, sel_ctrl, sel_stat, sel_mask, sel_txp;
	logic [31:0] prdata_q, prdata_d, ctrl_q, ctrl_d;
	logic snap_empty_q, snap_empty_d;
	logic [cmhl_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, snap_q, snap_d;
	logic [cmhl_pkg::IRQ_W-1:0] evt;
	logic irq_q, irq_d, init;
	logic rx_empty, rx_ovf, tx_empty, tx_ovf, rx_ovf_q, tx_ovf_q;
	logic rx_take, tx_take, rx_clr;
	logic [7:0] rx_last, rx_head, tx_last, tx_head;
	logic [RPW:0] rx_count;
	logic [TPW:0] tx_count;

	////////////////////////////////////////////////////////////////////////
	// APB decode; every register is one aligned word
	assign idx = I_PADDR[cmhl_pkg::ADDR_W-1:2];
	assign setup = I_PSEL && !I_PENABLE;
	assign acc = I_PSEL && I_PENABLE;
	assign rd_acc = acc && !I_PWRITE;
	assign wr_acc = acc && I_PWRITE;
	assign sel_ltx = (idx == cmhl_pkg::LAST_TX_IDX);
	assign sel_rxp = (idx == cmhl_pkg::RX_PORT_IDX);
	assign sel_lrx = (idx == cmhl_pkg::LAST_RX_IDX);
	assign sel_ctrl = (idx == cmhl_pkg::CTRL_IDX);
	assign sel_stat = (idx == cmhl_pkg::IRQ_STAT_IDX);
	assign sel_mask = (idx == cmhl_pkg::IRQ_MASK_IDX);
	assign sel_txp = (idx == cmhl_pkg::TX_PORT_IDX);
	assign mapped = sel_ltx || sel_rxp || sel_lrx || sel_ctrl || sel_stat
		|| sel_mask || sel_txp;
	// Zero wait states: read data is latched in the setup cycle
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = acc && !mapped;
	assign O_PRDATA = prdata_q;
	assign init = ctrl_q[cmhl_pkg::CTRL_INIT_BIT];

	////////////////////////////////////////////////////////////////////////
	// Read data and read side effects
	always_comb begin
		prdata_d = prdata_q;
		snap_empty_d = snap_empty_q;
		snap_d = snap_q;
		if (setup && !I_PWRITE) begin
			prdata_d = '0;
			snap_empty_d = sel_rxp ? rx_empty : tx_empty;
			snap_d = stat_q;
			if (sel_lrx)
				prdata_d[7:0] = rx_last;
			if (sel_ltx)
				prdata_d[7:0] = tx_last;
			if (sel_rxp) begin
				prdata_d[cmhl_pkg::PORT_DATA_LSB+:8] = rx_head;
				prdata_d[cmhl_pkg::PORT_EMPTY_BIT] = rx_empty;
				prdata_d[cmhl_pkg::PORT_OVF_BIT] = rx_ovf;
			end
			if (sel_txp) begin
				prdata_d[cmhl_pkg::PORT_DATA_LSB+:8] = tx_head;
				prdata_d[cmhl_pkg::PORT_EMPTY_BIT] = tx_empty;
				prdata_d[cmhl_pkg::PORT_OVF_BIT] = tx_ovf;
			end
			if (sel_ctrl)
				prdata_d = ctrl_q;
			if (sel_stat)
				prdata_d[cmhl_pkg::IRQ_W-1:0] = stat_q;
			if (sel_mask)
				prdata_d[cmhl_pkg::IRQ_W-1:0] = mask_q;
		end
	end

	// Advance only if the word handed out held a valid entry, so a store
	// landing between setup and access is never skipped unseen
	assign rx_take = rd_acc && sel_rxp && !snap_empty_q;
	assign tx_take = rd_acc && sel_txp && !snap_empty_q;
	assign rx_clr = wr_acc && sel_rxp
		&& I_PWDATA[cmhl_pkg::PORT_OVF_BIT];

	////////////////////////////////////////////////////////////////////////
	// Control, mask and interrupt status
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		if (wr_acc && sel_ctrl)
			ctrl_d = {31'h0000_0000, I_PWDATA[cmhl_pkg::CTRL_INIT_BIT]};
		if (wr_acc && sel_mask)
			mask_d = I_PWDATA[cmhl_pkg::IRQ_W-1:0];
		evt = '0;
		evt[cmhl_pkg::IRQ_RX_STORED] = I_RX_EVT.valid && !init;
		evt[cmhl_pkg::IRQ_TX_DONE] = I_TX_EVT.valid && !init;
		evt[cmhl_pkg::IRQ_RX_OVF] = rx_ovf && !rx_ovf_q;
		evt[cmhl_pkg::IRQ_TX_OVF] = tx_ovf && !tx_ovf_q;
		// Read clears only what was shown; new events win over the clear
		stat_d = stat_q;
		if (rd_acc && sel_stat)
			stat_d = stat_q & ~snap_q;
		stat_d = stat_d | evt;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			prdata_q <= '0;
			snap_empty_q <= 1'b1;
			snap_q <= cmhl_pkg::IRQ_RST;
			ctrl_q <= cmhl_pkg::CTRL_RST;
			mask_q <= cmhl_pkg::IRQ_RST;
			stat_q <= cmhl_pkg::IRQ_RST;
			irq_q <= 1'b0;
			rx_ovf_q <= 1'b0;
			tx_ovf_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			snap_empty_q <= snap_empty_d;
			snap_q <= snap_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			irq_q <= irq_d;
			rx_ovf_q <= rx_ovf;
			tx_ovf_q <= tx_ovf;
		end
	end

	assign O_IRQ = irq_q;

	////////////////////////////////////////////////////////////////////////
	// The two lists; init mode empties them, so last values go undefined
	cmhl_list #(.KEEP(RX_KEEP), .PW(RPW)) u_rx (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RESETN),
		.i_init(init),
		.i_take(rx_take),
		.i_clr_ovf(rx_clr),
		.i_evt(I_RX_EVT),
		.o_empty(rx_empty),
		.o_ovf(rx_ovf),
		.o_last(rx_last),
		.o_head(rx_head),
		.o_count(rx_count)
	);

	// Transmit overflow has no write clear here; init mode clears it
	cmhl_list #(.KEEP(TX_KEEP), .PW(TPW)) u_tx (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RESETN),
		.i_init(init),
		.i_take(tx_take),
		.i_clr_ovf(1'b0),
		.i_evt(I_TX_EVT),
		.o_empty(tx_empty),
		.o_ovf(tx_ovf),
		.o_last(tx_last),
		.o_head(tx_head),
		.o_count(tx_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);

	// Last registers are undefined while their list is empty after init
	// exit, so no property reads them there; every property skips reset

	a_rx_last_num: assert property (
		I_RX_EVT.valid && !init |=> rx_last == 8'($past(I_RX_EVT.buf_num)))
		else $error("last received number wrong");

	a_init_clears: assert property (
		init |=> rx_empty && tx_empty && !rx_ovf)
		else $error("init did not empty the lists");

	a_port_data: assert property (
		setup && !I_PWRITE && sel_rxp |=> O_PRDATA[15:8] == $past(rx_head))
		else $error("receive port data wrong");

	a_port_empty: assert property (
		setup && !I_PWRITE && sel_rxp
		|=> O_PRDATA[1] == (($past(rx_count)) == 0))
		else $error("receive port empty bit wrong");

	a_ovf_set: assert property (
		rx_count == RX_KEEP && I_RX_EVT.valid && !init
		|=> rx_ovf && rx_count == RX_KEEP - $past(rx_take))
		else $error("overflow not set on full list");

	a_store_append: assert property (
		!rx_ovf && rx_count < RX_KEEP && I_RX_EVT.valid && !init && !rx_take
		|=> rx_count == $past(rx_count) + 1 && !rx_empty)
		else $error("store not appended");

	a_ovf_keep_empty: assert property (
		rx_ovf && rx_empty && !init |=> rx_empty)
		else $error("empty cleared during overflow");

	a_ovf_clear: assert property (
		rx_clr && !I_RX_EVT.valid
		|=> !rx_ovf ##1 (!rx_ovf || $past(I_RX_EVT.valid)))
		else $error("overflow not cleared");

	a_tx_last_num: assert property (
		I_TX_EVT.valid && !init |=> tx_last == 8'($past(I_TX_EVT.buf_num)))
		else $error("last transmitted number wrong");

	a_tx_empty: assert property (
		I_TX_EVT.valid && !init && !tx_ovf && !tx_take |=> !tx_empty)
		else $error("transmit empty flag wrong");

	a_get_advance: assert property (
		rx_take && !I_RX_EVT.valid && !init
		|=> rx_count == $past(rx_count) - 1)
		else $error("get index did not advance");

	// Overflow flag reads back in bit 0 of the word that was handed out
	a_port_ovf: assert property (
		setup && !I_PWRITE && sel_rxp
		|=> O_PRDATA[cmhl_pkg::PORT_OVF_BIT] == $past(rx_ovf))
		else $error("receive port overflow bit wrong");

	// A write with bit 0 low must leave a set overflow flag alone
	a_clr_ignore: assert property (
		wr_acc && sel_rxp && !I_PWDATA[cmhl_pkg::PORT_OVF_BIT]
		&& rx_ovf && !init
		|=> rx_ovf)
		else $error("overflow cleared by a zero write");

	// Reading the last entry out sets the empty flag even in overflow
	a_ovf_read_empty: assert property (
		rx_ovf && rx_take && rx_count == 1 && !init
		|=> rx_empty)
		else $error("empty not set after final read");

	// Transmit list: a store into a full list overflows and stays unread
	a_tx_ovf_set: assert property (
		tx_count == TX_KEEP && I_TX_EVT.valid && !init
		|=> tx_ovf && !tx_empty
		&& tx_count == TX_KEEP - $past(tx_take))
		else $error("transmit overflow not set on full list");

	// Each transmit port read that showed an entry consumes it
	a_tx_take_advance: assert property (
		tx_take && tx_count != 0 && !I_TX_EVT.valid && !init
		|=> tx_count == $past(tx_count) - 1)
		else $error("transmit get index did not advance");

	// Transmit empty bit shows whether unread entries were held at setup
	a_tx_port_empty: assert property (
		setup && !I_PWRITE && sel_txp
		|=> O_PRDATA[cmhl_pkg::PORT_EMPTY_BIT]
			== ($past(tx_count) == 0))
		else $error("transmit port empty bit wrong");

	// Main scenarios
	c_rx_read: cover property (rx_take ##1 rx_empty);
	c_rx_ovf: cover property (!rx_ovf ##1 rx_ovf ##[1:200] rx_clr);
	c_tx_ovf: cover property (!tx_ovf ##1 tx_ovf);
	c_tx_read: cover property (tx_take);
	c_irq: cover property (!O_IRQ ##1 O_IRQ);

endmodule // cmhl_top
`default_nettype wire

/* File: test/cmhl_top_tb_top.sv */
// Self-checking testbench for the receive and transmit history lists
`timescale 1ns/1ps
`default_nettype none
module cmhl_top_tb_top;
////////////////////////////////////////////////////////////////////////////
// Stimulus and observation signals
logic I_REF_CLK = 1'b0;
logic I_RESETN = 1'b0;
logic I_PSEL = 1'b0;
logic I_PENABLE = 1'b0;
logic I_PWRITE = 1'b0;
logic [cmhl_pkg::ADDR_W-1:0] I_PADDR = '0;
logic [31:0] I_PWDATA = 32'h0000_0000;
logic [31:0] O_PRDATA;
logic O_PREADY;
logic O_PSLVERR;
cmhl_pkg::cmhl_evt_type I_RX_EVT = '0;
cmhl_pkg::cmhl_evt_type I_TX_EVT = '0;
logic O_IRQ;
int fails = 0;
int samples_checked = 0;
logic [31:0] rd_q;
logic err_q;
localparam logic [15:0] RX = cmhl_pkg::RX_PORT_IDX;
localparam logic [15:0] TX = cmhl_pkg::TX_PORT_IDX;
localparam logic [15:0] STAT = cmhl_pkg::IRQ_STAT_IDX;

// Device under test
cmhl_top cmhl_top_i (
	.I_REF_CLK(I_REF_CLK),
	.I_RESETN(I_RESETN),
	.I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA),
	.O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR),
	.I_RX_EVT(I_RX_EVT),
	.I_TX_EVT(I_TX_EVT),
	.O_IRQ(O_IRQ)
);

// 50 MHz reference clock
always #10 I_REF_CLK = ~I_REF_CLK;

////////////////////////////////////////////////////////////////////////////
// Shared tasks

// Compare and count; an unknown never matches
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	samples_checked++;
	if (got !== exp) begin
		fails++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask

// One APB transfer; request held until pready is seen at an edge
task automatic apb(input logic wr, input logic [15:0] idx,
		input logic [31:0] wd);
	@(posedge I_REF_CLK);
	I_PSEL <= 1'b1;
	I_PWRITE <= wr;
	I_PADDR <= {idx, 2'b00};
	I_PWDATA <= wd;
	@(posedge I_REF_CLK);
	I_PENABLE <= 1'b1;
	@(posedge I_REF_CLK);
	while (O_PREADY !== 1'b1) @(posedge I_REF_CLK);
	rd_q = O_PRDATA;
	err_q = O_PSLVERR;
	I_PSEL <= 1'b0;
	I_PENABLE <= 1'b0;
endtask

// Read a history port; the number field means nothing while empty
task automatic rd_port(input logic [15:0] idx, input logic [3:0] num,
		input logic emp, input logic ovf);
	apb(1'b0, idx, 32'h0000_0000);
	chk(emp ? (rd_q & 32'hFFFF_00FF) : rd_q,
		{16'h0000, 4'h0, num, 6'h00, emp, ovf});
endtask

// Back-to-back frame events with consecutive buffer numbers
task automatic evts(input logic tx, input int first, input int n);
	for (int k = 0; k < n; k++) begin
		@(posedge I_REF_CLK);
		if (tx) I_TX_EVT <= {1'b1, 4'(first + k)};
		else I_RX_EVT <= {1'b1, 4'(first + k)};
	end
	@(posedge I_REF_CLK);
	I_RX_EVT <= '0;
	I_TX_EVT <= '0;
endtask

task automatic summarize;
	$display("checks=%0d fails=%0d", samples_checked, fails);
	if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////
// Scenarios

// Init mode ignores frames; unmapped access errors
task automatic t_init;
	apb(1'b0, cmhl_pkg::CTRL_IDX, 32'h0000_0000);
	chk(rd_q, cmhl_pkg::CTRL_RST);
	evts(1'b0, 5, 1);
	apb(1'b1, cmhl_pkg::CTRL_IDX, 32'h0000_0000);
	rd_port(RX, 4'h0, 1'b1, 1'b0);
	apb(1'b0, 16'h0010, 32'h0000_0000);
	chk(rd_q, 32'h0000_0000);
	chk({31'h0, err_q}, 32'h0000_0001);
endtask

// Entries come back oldest first, then the list reads empty
task automatic t_rx_order;
	evts(1'b0, 13, 3);
	apb(1'b0, cmhl_pkg::LAST_RX_IDX, 32'h0000_0000);
	chk(rd_q, 32'h0000_000F);
	for (int k = 0; k < 3; k++) rd_port(RX, 4'(13 + k), 1'b0, 1'b0);
	rd_port(RX, 4'h0, 1'b1, 1'b0);
endtask

// Overflow exactly at the 23rd store; the newest slot is overwritten
task automatic t_rx_ovf;
	apb(1'b0, STAT, 32'h0000_0000);
	evts(1'b0, 0, 22);
	apb(1'b0, STAT, 32'h0000_0000);
	chk({31'h0, rd_q[cmhl_pkg::IRQ_RX_OVF]}, 32'h0000_0000);
	evts(1'b0, 22, 1);
	apb(1'b0, STAT, 32'h0000_0000);
	chk({31'h0, rd_q[cmhl_pkg::IRQ_RX_OVF]}, 32'h0000_0001);
	for (int k = 0; k < 21; k++) rd_port(RX, 4'(k), 1'b0, 1'b1);
	rd_port(RX, 4'h6, 1'b0, 1'b1);
	rd_port(RX, 4'h0, 1'b1, 1'b1);
	evts(1'b0, 9, 1);
	rd_port(RX, 4'h0, 1'b1, 1'b1);
	// Only bit 0 set to one may clear the flag
	apb(1'b1, RX, 32'hFFFF_FFFE);
	rd_port(RX, 4'h0, 1'b1, 1'b1);
	apb(1'b1, RX, 32'h0000_0001);
	rd_port(RX, 4'h0, 1'b1, 1'b0);
	evts(1'b0, 10, 1);
	rd_port(RX, 4'hA, 1'b0, 1'b0);
	apb(1'b0, cmhl_pkg::LAST_RX_IDX, 32'h0000_0000);
	chk(rd_q, 32'h0000_000A);
endtask

// Transmit list: newest number and the empty flag
task automatic t_tx;
	evts(1'b1, 2, 3);
	apb(1'b0, cmhl_pkg::LAST_TX_IDX, 32'h0000_0000);
	chk(rd_q, 32'h0000_0004);
	for (int k = 0; k < 3; k++) rd_port(TX, 4'(2 + k), 1'b0, 1'b0);
	rd_port(TX, 4'h0, 1'b1, 1'b0);
endtask

// Interrupt raised when unmasked, cleared by a status read, kept low when masked
task automatic t_irq;
	apb(1'b1, cmhl_pkg::IRQ_MASK_IDX, 32'h0000_0001);
	apb(1'b0, STAT, 32'h0000_0000);
	repeat (2) @(posedge I_REF_CLK);
	chk({31'h0, O_IRQ}, 32'h0000_0000);
	evts(1'b0, 1, 1);
	repeat (2) @(posedge I_REF_CLK);
	chk({31'h0, O_IRQ}, 32'h0000_0001);
	apb(1'b0, STAT, 32'h0000_0000);
	chk({31'h0, rd_q[cmhl_pkg::IRQ_RX_STORED]}, 32'h0000_0001);
	repeat (2) @(posedge I_REF_CLK);
	chk({31'h0, O_IRQ}, 32'h0000_0000);
	apb(1'b1, cmhl_pkg::IRQ_MASK_IDX, 32'h0000_0000);
	evts(1'b0, 2, 1);
	repeat (2) @(posedge I_REF_CLK);
	chk({31'h0, O_IRQ}, 32'h0000_0000);
endtask

// Transmit overflow overwrites the newest slot; init empties both lists
task automatic t_tx_ovf;
	evts(1'b1, 0, 7);
	apb(1'b0, cmhl_pkg::LAST_TX_IDX, 32'h0000_0000);
	chk(rd_q, 32'h0000_0006);
	apb(1'b0, STAT, 32'h0000_0000);
	chk({31'h0, rd_q[cmhl_pkg::IRQ_TX_OVF]}, 32'h0000_0001);
	rd_port(TX, 4'h0, 1'b0, 1'b1);
	rd_port(RX, 4'h1, 1'b0, 1'b0);
	apb(1'b1, cmhl_pkg::CTRL_IDX, 32'h0000_0001);
	apb(1'b1, cmhl_pkg::CTRL_IDX, 32'h0000_0000);
	rd_port(TX, 4'h0, 1'b1, 1'b0);
	rd_port(RX, 4'h0, 1'b1, 1'b0);
endtask

////////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
	repeat (20) @(posedge I_REF_CLK);
	I_RESETN <= 1'b1;
	t_init();
	t_rx_order();
	t_rx_ovf();
	t_tx();
	t_irq();
	t_tx_ovf();
	summarize();
end

// Watchdog: the tests need well under a thousand cycles
initial begin
	repeat (20000) @(posedge I_REF_CLK);
	fails++;
	summarize();
end

endmodule // cmhl_top_tb_top
`default_nettype wire
